// ---- hdl/spi_port_pkg.sv ----
// Purpose: shared constants and carriers for the serial port
// Assumes: single 25 MHz system clock
// Notes: control and status travel as packed structs
package spi_port_pkg;

  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam logic [2:0] RATE_CODE_NONE_LO = 3'h0;
  localparam logic [2:0] RATE_CODE_NONE_HI = 3'h7;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [2:0] BIT_COUNT_LAST = 3'h7;
  localparam int unsigned RATE_CNT_W = 7;

  typedef struct packed {
    logic port_enable_bit;
    logic master_select_bit;
    logic clock_polarity_bit;
    logic clock_phase_bit;
    logic select_disable_bit;
    logic [2:0] rate_select;
  } serial_control_t;

  typedef struct packed {
    logic transfer_done_flag;
    logic mode_fault_flag;
    logic overrun_flag;
    logic tx_empty_flag;
  } serial_status_t;

  typedef struct packed {
    logic sck_o;
    logic sck_oe;
    logic mosi_o;
    logic mosi_oe;
    logic miso_o;
    logic miso_oe;
  } serial_pins_t;

endpackage

// ---- hdl/rate_divider.sv ----
// Purpose: master serial clock half-period tick generator
// Assumes: rate code 1..6 selects divisor 4..128
// Notes: codes 0 and 7 produce no ticks
`timescale 1ns/1ps
`default_nettype none
module rate_divider
  import spi_port_pkg::*;
#(
  parameter int unsigned CNT_W = RATE_CNT_W
)
(
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_run,
  input wire logic [2:0] i_rate_select,
  output logic o_half_tick
);

  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] half_last;
  logic rate_valid;

  // divisor is 2^(code+1), so a half period is 2^code cycles
  always_comb
  begin
    rate_valid = (i_rate_select != RATE_CODE_NONE_LO) && (i_rate_select != RATE_CODE_NONE_HI);
    half_last = CNT_W'((CNT_W'(1) << i_rate_select) - CNT_W'(1));
  end

  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      count_reg <= '0;
      o_half_tick <= 1'b0;
    end
    else if (!i_run || !rate_valid)
    begin
      count_reg <= '0;
      o_half_tick <= 1'b0;
    end
    else if (count_reg == half_last)
    begin
      count_reg <= '0;
      o_half_tick <= 1'b1;
    end
    else
    begin
      count_reg <= CNT_W'(count_reg + CNT_W'(1));
      o_half_tick <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ---- hdl/spi_master_slave_port.sv ----
// Purpose: full-duplex serial port, master or slave
// Assumes: pins synchronous to i_ref_clk; slave clock at most fsys/4
// Notes:
`timescale 1ns/1ps
`default_nettype none
module spi_master_slave_port
  import spi_port_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_ctrl_write,
  input wire serial_control_t i_ctrl_data,
  input wire logic i_status_read,
  input wire logic i_data_write,
  input wire logic [7:0] i_data_wdata,
  input wire logic i_data_read,
  input wire logic i_sck,
  input wire logic i_mosi,
  input wire logic i_miso,
  input wire logic i_select_n,
  output serial_control_t o_control,
  output serial_status_t o_status,
  output logic [7:0] o_rx_data,
  output logic o_irq,
  output serial_pins_t o_pins
);

  serial_control_t serial_control_reg;
  serial_status_t serial_status_reg;
  logic [7:0] serial_data_reg;
  logic [7:0] tx_hold_reg;
  logic tx_full_reg;
  logic [7:0] shift_reg;
  logic [2:0] bit_cnt_reg;
  logic busy_reg;
  logic sck_reg;
  logic slave_load;
  logic in_bit_reg;
  logic sck_prev_reg;
  logic sel_prev_reg;
  logic done_armed_reg;
  logic fault_armed_reg;
  logic half_tick;
  logic is_master;
  logic slave_sel;
  logic sck_edge;
  logic lead_edge;
  logic trail_edge;
  logic byte_done;
  logic master_fault;
  logic master_start;

  ////////////////////////////////////////////////////////////////
  always_comb
  begin
    is_master = serial_control_reg.port_enable_bit && serial_control_reg.master_select_bit;
    // phase one plus disable makes the slave always selected
    slave_sel = serial_control_reg.port_enable_bit && !serial_control_reg.master_select_bit
      && (!i_select_n
      || (serial_control_reg.clock_phase_bit && serial_control_reg.select_disable_bit));
    // fault only while select pin is honoured
    master_fault = is_master && !serial_control_reg.select_disable_bit && !i_select_n;
    master_start = is_master && !busy_reg && tx_full_reg && !master_fault;
    sck_edge = is_master ? (busy_reg && half_tick) : (slave_sel && (i_sck != sck_prev_reg));
    // lead edge leaves idle level
    lead_edge = sck_edge && (is_master ? (sck_reg == serial_control_reg.clock_polarity_bit)
      : (sck_prev_reg == serial_control_reg.clock_polarity_bit));
    trail_edge = sck_edge && !lead_edge;
    byte_done = trail_edge && (bit_cnt_reg == BIT_COUNT_LAST);
    // phase zero loads on select fall, phase one on the first edge
    slave_load = !is_master && slave_sel && !busy_reg && tx_full_reg
      && (serial_control_reg.clock_phase_bit ? lead_edge : (sel_prev_reg && !i_select_n));
  end

  rate_divider #(
    .CNT_W(RATE_CNT_W)
  ) u_rate (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_run(busy_reg && is_master),
    .i_rate_select(serial_control_reg.rate_select),
    .o_half_tick(half_tick)
  );

  ////////////////////////////////////////////////////////////////
  // control: fault drops enable and master
  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
      serial_control_reg <= '0;
    else if (master_fault)
    begin
      serial_control_reg.port_enable_bit <= 1'b0;
      serial_control_reg.master_select_bit <= 1'b0;
    end
    else if (i_ctrl_write)
      serial_control_reg <= i_ctrl_data;
  end

  // transmit holding byte; stays queued if the slave write was late
  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      tx_hold_reg <= DATA_RESET;
      tx_full_reg <= 1'b0;
    end
    else if (i_data_write)
    begin
      tx_hold_reg <= i_data_wdata;
      tx_full_reg <= 1'b1;
    end
    else if (master_start || slave_load)
      tx_full_reg <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////
  // shifting engine
  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      shift_reg <= DATA_RESET;
      bit_cnt_reg <= '0;
      busy_reg <= 1'b0;
      in_bit_reg <= 1'b0;
    end
    else if (!serial_control_reg.port_enable_bit || (!is_master && !slave_sel))
    begin
      // deselect clears the bit counter and aborts
      bit_cnt_reg <= '0;
      busy_reg <= 1'b0;
    end
    else if (master_start)
    begin
      shift_reg <= tx_hold_reg;
      bit_cnt_reg <= '0;
      busy_reg <= 1'b1;
    end
    else
    begin
      if (!is_master && !busy_reg && sck_edge)
        busy_reg <= 1'b1;
      if (slave_load)
        shift_reg <= tx_hold_reg;
      // phase zero: sample on lead, shift on trail; phase one reversed
      if (lead_edge != serial_control_reg.clock_phase_bit)
        in_bit_reg <= is_master ? i_miso : i_mosi;
      // phase one: first lead edge only opens the byte, msb already out
      if (lead_edge == serial_control_reg.clock_phase_bit && sck_edge
        && !(serial_control_reg.clock_phase_bit && bit_cnt_reg == '0 && lead_edge))
        shift_reg <= {shift_reg[6:0], in_bit_reg};
      if (trail_edge)
      begin
        bit_cnt_reg <= 3'(bit_cnt_reg + 3'h1);
        if (byte_done)
          busy_reg <= 1'b0;
      end
    end
  end

  // phase one samples its last bit on the final edge itself
  logic [7:0] rx_byte;
  always_comb
  begin
    rx_byte = serial_control_reg.clock_phase_bit ? {shift_reg[6:0], is_master ? i_miso : i_mosi}
      : {shift_reg[6:0], in_bit_reg};
  end

  ////////////////////////////////////////////////////////////////
  // master clock generator; idles at polarity level
  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
      sck_reg <= 1'b0;
    else if (!busy_reg || !is_master)
      sck_reg <= serial_control_reg.clock_polarity_bit;
    else if (half_tick)
      sck_reg <= !sck_reg;
  end

  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      sck_prev_reg <= 1'b0;
      sel_prev_reg <= 1'b1;
    end
    else
    begin
      sck_prev_reg <= i_sck;
      sel_prev_reg <= i_select_n;
    end
  end

  ////////////////////////////////////////////////////////////////
  // status flags: set wins over clear
  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      serial_status_reg <= '0;
      serial_data_reg <= DATA_RESET;
      done_armed_reg <= 1'b0;
      fault_armed_reg <= 1'b0;
    end
    else
    begin
      serial_status_reg.tx_empty_flag <= !tx_full_reg;
      if (i_status_read)
      begin
        done_armed_reg <= serial_status_reg.transfer_done_flag;
        fault_armed_reg <= serial_status_reg.mode_fault_flag;
      end
      if (byte_done && serial_status_reg.transfer_done_flag)
        serial_status_reg.overrun_flag <= 1'b1;
      else if (byte_done)
      begin
        serial_data_reg <= rx_byte;
        serial_status_reg.transfer_done_flag <= 1'b1;
      end
      else if (i_data_read && done_armed_reg)
      begin
        serial_status_reg.transfer_done_flag <= 1'b0;
        serial_status_reg.overrun_flag <= 1'b0;
        done_armed_reg <= 1'b0;
      end
      // a control write clears it only after a status read
      if (master_fault)
        serial_status_reg.mode_fault_flag <= 1'b1;
      else if (i_ctrl_write && fault_armed_reg)
      begin
        serial_status_reg.mode_fault_flag <= 1'b0;
        fault_armed_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // pin drivers
  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_pins <= '0;
      o_irq <= 1'b0;
    end
    else
    begin
      o_pins.sck_o <= sck_reg;
      o_pins.sck_oe <= is_master;
      o_pins.mosi_o <= shift_reg[7];
      o_pins.mosi_oe <= is_master;
      o_pins.miso_o <= shift_reg[7];
      o_pins.miso_oe <= slave_sel;
      o_irq <= serial_status_reg.mode_fault_flag || serial_status_reg.transfer_done_flag;
    end
  end

  assign o_control = serial_control_reg;
  assign o_status = serial_status_reg;
  assign o_rx_data = serial_data_reg;

  ////////////////////////////////////////////////////////////////
  property p_fault_disables;
    @(posedge i_ref_clk) disable iff (i_reset)
    master_fault |=> !serial_control_reg.master_select_bit && serial_status_reg.mode_fault_flag;
  endproperty
  a_fault_disables: assert property (p_fault_disables) else $error("fault kept master");

  property p_done_sets;
    @(posedge i_ref_clk) disable iff (i_reset)
    byte_done |=> serial_status_reg.transfer_done_flag;
  endproperty
  a_done_sets: assert property (p_done_sets) else $error("done flag not set");

  property p_overrun_keeps;
    @(posedge i_ref_clk) disable iff (i_reset)
    byte_done && serial_status_reg.transfer_done_flag |=> $stable(serial_data_reg);
  endproperty
  a_overrun_keeps: assert property (p_overrun_keeps) else $error("unread byte lost");

  property p_idle_clock;
    @(posedge i_ref_clk) disable iff (i_reset)
    !busy_reg |=> sck_reg == $past(serial_control_reg.clock_polarity_bit);
  endproperty
  a_idle_clock: assert property (p_idle_clock) else $error("idle clock wrong");

  property p_no_fault_disabled;
    @(posedge i_ref_clk) disable iff (i_reset)
    is_master && serial_control_reg.select_disable_bit |-> !master_fault;
  endproperty
  a_no_fault_disabled: assert property (p_no_fault_disabled) else $error("fault while off");

  property p_start_load;
    @(posedge i_ref_clk) disable iff (i_reset)
    master_start |=> busy_reg && shift_reg == $past(tx_hold_reg);
  endproperty
  a_start_load: assert property (p_start_load) else $error("start not loaded");

  property p_miso_tristate;
    @(posedge i_ref_clk) disable iff (i_reset)
    !serial_control_reg.master_select_bit && i_select_n
      && !(serial_control_reg.clock_phase_bit && serial_control_reg.select_disable_bit)
      |=> !o_pins.miso_oe;
  endproperty
  a_miso_tristate: assert property (p_miso_tristate) else $error("miso driven");

  property p_done_clear;
    @(posedge i_ref_clk) disable iff (i_reset)
    i_data_read && done_armed_reg && !byte_done |=> !serial_status_reg.transfer_done_flag;
  endproperty
  a_done_clear: assert property (p_done_clear) else $error("done not cleared");

endmodule
`default_nettype wire

// ---- verif/spi_peer_model.sv ----
// Purpose: slave peer standing on the master serial pins
// Assumes: pin levels are sampled on the falling system clock edge
// Notes: its data line is always driven, never left floating
`timescale 1ns/1ps
`default_nettype none
module spi_peer_model
  import spi_port_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_load,
  input wire logic i_polarity,
  input wire logic i_phase,
  input wire logic [7:0] i_tx,
  input wire serial_pins_t i_pins,
  output logic o_miso,
  output logic [7:0] o_rx,
  output logic [4:0] o_edges,
  output logic [7:0] o_gap
);
  logic prev;
  logic lead;
  logic [7:0] sr;
  logic [7:0] cnt;
  assign lead = i_pins.sck_o ^ i_polarity;
  // falling edge: answers within half a cycle, as a fast peer would
  always_ff @(negedge i_ref_clk)
  begin
    prev <= i_pins.sck_o;
    cnt <= cnt + 8'h01;
    if (i_load)
    begin
      sr <= i_tx;
      // phase one: wrong bit until the first edge, so early capture shows
      o_miso <= i_tx[7] ^ i_phase;
      o_edges <= 5'h00;
    end
    else if (i_pins.sck_o != prev)
    begin
      o_edges <= o_edges + 5'h01;
      o_gap <= cnt + 8'h01;
      cnt <= 8'h00;
      if (lead ^ i_phase)
        o_rx <= {o_rx[6:0], i_pins.mosi_o};
      else
      begin
        o_miso <= i_phase ? sr[7] : sr[6];
        sr <= {sr[6:0], 1'b0};
      end
    end
  end
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
// Purpose: self-checking bench for the serial port
// Assumes: peer model stands on the master pins
// Notes: slave mode pins are driven by hand from the bench
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import spi_port_pkg::*;
  logic i_ref_clk, i_reset, i_ctrl_write, i_status_read, i_data_write, i_data_read;
  logic i_sck, i_mosi, i_select_n, miso, p_load, p_polarity, p_phase, o_irq;
  logic [7:0] i_data_wdata, o_rx_data, p_tx, p_rx, p_gap, mi;
  logic [4:0] p_edges;
  serial_control_t i_ctrl_data, o_control, c;
  serial_status_t o_status;
  serial_pins_t o_pins;
  int n_errors, comparisons;

  spi_master_slave_port u_spi_master_slave_port (.i_ref_clk(i_ref_clk),
    .i_reset(i_reset), .i_ctrl_write(i_ctrl_write), .i_ctrl_data(i_ctrl_data),
    .i_status_read(i_status_read), .i_data_write(i_data_write),
    .i_data_wdata(i_data_wdata), .i_data_read(i_data_read), .i_sck(i_sck),
    .i_mosi(i_mosi), .i_miso(miso), .i_select_n(i_select_n), .o_control(o_control),
    .o_status(o_status), .o_rx_data(o_rx_data), .o_irq(o_irq), .o_pins(o_pins));
  spi_peer_model u_spi_peer_model (.i_ref_clk(i_ref_clk), .i_load(p_load),
    .i_polarity(p_polarity), .i_phase(p_phase), .i_tx(p_tx), .i_pins(o_pins), .o_miso(miso),
    .o_rx(p_rx), .o_edges(p_edges), .o_gap(p_gap));

  initial
  begin
    i_ref_clk = 1'b0;
    forever #20 i_ref_clk = ~i_ref_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    if (n_errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("FAIL %0t %s got %h expected %h", $time, m, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask
  task automatic wr_ctrl(input serial_control_t v);
    @(posedge i_ref_clk);
    i_ctrl_write <= 1'b1;
    i_ctrl_data <= v;
    @(posedge i_ref_clk);
    i_ctrl_write <= 1'b0;
  endtask
  task automatic wr_data(input logic [7:0] d);
    @(posedge i_ref_clk);
    i_data_write <= 1'b1;
    i_data_wdata <= d;
    @(posedge i_ref_clk);
    i_data_write <= 1'b0;
  endtask
  // st high reads status, low reads data
  task automatic rd(input logic st);
    @(posedge i_ref_clk);
    i_status_read <= st;
    i_data_read <= ~st;
    @(posedge i_ref_clk);
    i_status_read <= 1'b0;
    i_data_read <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // codes 1..6 also walk all four polarity and phase pairs
  task automatic mxfer(input logic [2:0] code);
    logic [7:0] tx;
    tx = {code, 5'h15};
    c = '{1'b1, 1'b1, code[1], code[0], 1'b0, code};
    wr_ctrl(c);
    tick(2);
    p_tx <= ~tx;
    p_polarity <= code[1];
    p_phase <= code[0];
    p_load <= 1'b1;
    tick(1);
    p_load <= 1'b0;
    wr_data(tx);
    for (int k = 0; k < 2500 && o_status.transfer_done_flag !== 1'b1; k++)
      tick(1);
    chk(8'(o_status.transfer_done_flag), 8'h01, "done");
    chk(o_rx_data, ~tx, "master rx");
    tick(2 << code);
    chk(p_rx, tx, "peer rx");
    chk(8'(p_edges), 8'h10, "edges");
    chk(p_gap, 8'(1 << code), "half period");
    chk(8'(o_pins.sck_o), 8'(code[1]), "idle level");
    chk(8'({o_pins.sck_oe, o_pins.mosi_oe}), 8'h03, "master drives");
    chk(8'(o_irq), 8'h01, "irq");
    rd(1'b0);
    chk(8'(o_status.transfer_done_flag), 8'h01, "data read alone");
    rd(1'b1);
    rd(1'b0);
    tick(1);
    chk(8'(o_status.transfer_done_flag), 8'h00, "done cleared");
  endtask
  task automatic sxfer(input logic [7:0] mo);
    i_select_n <= 1'b0;
    tick(4);
    chk(8'(o_pins.miso_oe), 8'h01, "miso driven");
    for (int i = 7; i >= 0; i--)
    begin
      i_mosi <= mo[i];
      tick(4);
      mi[i] = o_pins.miso_o;
      i_sck <= 1'b1;
      tick(4);
      i_sck <= 1'b0;
    end
    tick(4);
    i_select_n <= 1'b1;
    tick(4);
    chk(8'(o_pins.miso_oe), 8'h00, "miso released");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge i_ref_clk);
    n_errors++;
    $display("FAIL %0t watchdog expired", $time);
    wrap_up;
  end
  initial
  begin
    {i_reset, p_load, i_select_n} = 3'h7;
    {i_ctrl_write, i_status_read, i_data_write, i_data_read, i_sck, i_mosi} = 6'h00;
    {p_polarity, p_phase, i_data_wdata, p_tx} = 18'h0_0000;
    i_ctrl_data = '0;
    n_errors = 0;
    comparisons = 0;
    tick(3);
    i_reset <= 1'b0;
    tick(1);
    chk(8'(o_control), 8'h00, "control reset");
    for (int k = 1; k < 7; k++)
      mxfer(3'(k));
    c = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 3'h1};
    wr_ctrl(c);
    wr_data(8'hC3);
    tick(2);
    chk(8'(o_status.tx_empty_flag), 8'h00, "queued");
    sxfer(8'h96);
    chk(mi, 8'hC3, "slave tx");
    chk(o_rx_data, 8'h96, "slave rx");
    chk(8'(o_status.transfer_done_flag), 8'h01, "slave done");
    chk(8'(o_status.tx_empty_flag), 8'h01, "queue drained");
    sxfer(8'h4B);
    chk(mi, 8'h96, "stale tx");
    chk(o_rx_data, 8'h96, "unread kept");
    chk(8'(o_status.overrun_flag), 8'h01, "overrun");
    rd(1'b1);
    rd(1'b0);
    c = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 3'h1};
    wr_ctrl(c);
    tick(4);
    chk(8'(o_pins.miso_oe), 8'h01, "always selected");
    c = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 3'h1};
    wr_ctrl(c);
    i_select_n <= 1'b0;
    tick(8);
    chk(8'(o_status.mode_fault_flag), 8'h00, "no fault");
    chk(8'(o_irq), 8'h00, "no irq");
    c.select_disable_bit = 1'b0;
    wr_ctrl(c);
    for (int k = 0; k < 20 && o_status.mode_fault_flag !== 1'b1; k++)
      tick(1);
    chk(8'(o_status.mode_fault_flag), 8'h01, "fault");
    chk(8'(o_control.port_enable_bit), 8'h00, "enable off");
    chk(8'(o_control.master_select_bit), 8'h00, "master off");
    tick(1);
    chk(8'(o_irq), 8'h01, "fault irq");
    i_select_n <= 1'b1;
    c = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 3'h1};
    wr_ctrl(c);
    c.select_disable_bit = 1'b0;
    wr_ctrl(c);
    tick(1);
    chk(8'(o_status.mode_fault_flag), 8'h01, "fault kept");
    rd(1'b1);
    wr_ctrl(c);
    tick(1);
    chk(8'(o_status.mode_fault_flag), 8'h00, "fault cleared");
    wrap_up;
  end
endmodule
`default_nettype wire
